// ==== design/ddac_defines.svh ====
// Constants for the dual converter serial write link and its two ends
// Assumes inclusion by bare name from package and design files
`ifndef DDAC_DEFINES_SVH
`define DDAC_DEFINES_SVH
`define DDAC_WORD_BITS 16
`define DDAC_CODE_BITS 10
`define DDAC_CNT_BITS 5
`define DDAC_LAST_BIT 5'h10
`define DDAC_LEAD_HI 15
`define DDAC_LEAD_LO 14
`define DDAC_OP_HI 13
`define DDAC_OP_LO 12
`define DDAC_CODE_MSB 11
`define DDAC_CODE_LSB 2
`define DDAC_CLK_NS 100
`define DDAC_WAKE_NS 800
`define DDAC_WAKE_CYC ((`DDAC_WAKE_NS + `DDAC_CLK_NS - 1) / `DDAC_CLK_NS)
`define DDAC_SCLK_HALF 3'h2
`define DDAC_DATA_TICK 3'h1
`define DDAC_GAP_CYC 3'h2
`define DDAC_ADDR_CMD 2'h0
`define DDAC_ADDR_STAT 2'h1
`define DDAC_ADDR_OUTS 2'h2
`define DDAC_ADDR_TERM 2'h3
`endif

// ==== design/ddac_pkg.sv ====
// Types shared by both ends of the dual converter serial link
// Assumes ddac_defines.svh on the include path
`include "ddac_defines.svh"
package ddac_pkg;
  typedef logic [`DDAC_CODE_BITS-1:0] ddac_code_t;
  typedef logic [`DDAC_WORD_BITS-1:0] ddac_word_t;
  // Operation field encoding
  typedef enum logic [1:0] {
    DDAC_OP_LOAD = 2'h0,
    DDAC_OP_LOAD_UPD = 2'h1,
    DDAC_OP_BOTH_UPD = 2'h2,
    DDAC_OP_PWRDN = 2'h3
  } ddac_op_e;
  // Output termination while powered down
  typedef enum logic [1:0] {
    DDAC_TERM_HIZ = 2'h0,
    DDAC_TERM_2K5 = 2'h1,
    DDAC_TERM_100K = 2'h2
  } ddac_term_e;
endpackage

// ==== design/ddac_link_if.sv ====
// Three-wire write-only link between host controller and converter
// Assumes both ends run on the same clk
`timescale 1ns/1ps
interface ddac_link_if;
  logic frame_n;
  logic sclk;
  logic sdata;
  modport host (output frame_n, output sclk, output sdata);
  modport device (input frame_n, input sclk, input sdata);
endinterface

// ==== design/ddac_sync2.sv ====
// Two-stage synchroniser for asynchronous link pins
// Assumes a single clock domain on the reading side
`timescale 1ns/1ps
module ddac_sync2 (
  input wire logic clk,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta;
  // First stage is read only by the second
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ==== design/ddac_device.sv ====
// Converter end: serial word capture, register control, power-down state
// Assumes link pins come from another party; frame_n resets high on the link
//
// Overview of operation
// - Low frame select shifts data on falling edges
// - Host never drops select on falling clock
// - Sixteenth edge executes the captured command
// - Extra clocks ignored until frame ends
// - Host raises select minimum time between frames
// - Host parks clock and data low
// - Early select rise discards partial frame
// - First bit zero, second selects channel
// - Two operation bits pick one of four
// - Codes straight binary, msb first, 0..1023
// - Power-up clears registers, outputs at zero
// - Operation 11 powers down both channels
// - Leading bits select output termination
// - Power-down keeps both channel registers
// - Outputs wake within typical wake time
// - Host stops clock during power-down
// - Host serial clock at most 40 MHz
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
module ddac_device (
  input wire logic clk,
  input wire logic resetn,
  ddac_link_if.device link,
  output ddac_pkg::ddac_code_t channel_a_output,
  output ddac_pkg::ddac_code_t channel_b_output,
  output ddac_pkg::ddac_code_t pending_a,
  output ddac_pkg::ddac_code_t pending_b,
  output logic powered_down,
  output ddac_pkg::ddac_term_e termination,
  output logic outputs_live,
  output logic word_done
);
  import ddac_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic frame_n_s;
  logic frame_sel_s;
  logic sclk_s;
  logic sdata_s;
  // Select is synchronised inverted so reset leaves the frame closed
  ddac_sync2 u_sync_frame (.clk(clk), .resetn(resetn), .async_in(~link.frame_n),
    .sync_out(frame_sel_s));
  assign frame_n_s = ~frame_sel_s;
  ddac_sync2 u_sync_sclk (.clk(clk), .resetn(resetn), .async_in(link.sclk),
    .sync_out(sclk_s));
  ddac_sync2 u_sync_data (.clk(clk), .resetn(resetn), .async_in(link.sdata),
    .sync_out(sdata_s));

  // ==========================================================
  // Edge detection
  logic sclk_d;
  logic sclk_fall;
  logic frame_open;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end
  assign sclk_fall = sclk_d & ~sclk_s;
  // Falling edges count only while select is low
  assign frame_open = ~frame_n_s;

  // ==========================================================
  // Shift register and bit counter
  ddac_word_t shift;
  logic [`DDAC_CNT_BITS-1:0] bit_cnt;
  logic take_bit;
  logic word_end;
  ddac_word_t word_now;
  // Counter saturates at sixteen so later clocks fall through
  assign take_bit = frame_open & sclk_fall & (bit_cnt != `DDAC_LAST_BIT);
  assign word_now = {shift[`DDAC_WORD_BITS-2:0], sdata_s}; // Msb first
  assign word_end = take_bit & (bit_cnt == `DDAC_LAST_BIT - 5'h1);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      shift <= '0;
    end else if (take_bit) begin
      shift <= word_now;
    end
  end

  // Select high clears the count, dropping any partial word
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bit_cnt <= '0;
    end else if (frame_n_s) begin
      bit_cnt <= '0;
    end else if (take_bit) begin
      bit_cnt <= bit_cnt + 5'h1;
    end
  end

  // ==========================================================
  // Command decode
  ddac_op_e op;
  logic chan_b;
  ddac_code_t code;
  logic [1:0] lead;
  assign op = ddac_op_e'(word_now[`DDAC_OP_HI:`DDAC_OP_LO]);
  assign chan_b = word_now[`DDAC_LEAD_LO];
  assign lead = word_now[`DDAC_LEAD_HI:`DDAC_LEAD_LO];
  assign code = word_now[`DDAC_CODE_MSB:`DDAC_CODE_LSB];

  // Pending registers, untouched by power-down
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pending_a <= '0;
      pending_b <= '0;
    end else if (word_end) begin
      unique case (op)
        DDAC_OP_LOAD, DDAC_OP_LOAD_UPD: begin
          if (chan_b) begin
            pending_b <= code;
          end else begin
            pending_a <= code;
          end
        end
        DDAC_OP_BOTH_UPD: begin
          pending_a <= code;
          pending_b <= code;
        end
        DDAC_OP_PWRDN: begin
          pending_a <= pending_a;
        end
      endcase
    end
  end

  // Output registers copy pending values on update operations
  always_ff @(posedge clk) begin
    if (!resetn) begin
      channel_a_output <= '0;
      channel_b_output <= '0;
    end else if (word_end) begin
      unique case (op)
        DDAC_OP_LOAD_UPD: begin
          channel_a_output <= chan_b ? pending_a : code;
          channel_b_output <= chan_b ? code : pending_b;
        end
        DDAC_OP_BOTH_UPD: begin
          channel_a_output <= code;
          channel_b_output <= code;
        end
        DDAC_OP_LOAD, DDAC_OP_PWRDN: begin
          channel_a_output <= channel_a_output;
        end
      endcase
    end
  end

  // ==========================================================
  // Power-down state and termination
  always_ff @(posedge clk) begin
    if (!resetn) begin
      powered_down <= 1'b0;
      termination <= DDAC_TERM_HIZ;
    end else if (word_end) begin
      if (op == DDAC_OP_PWRDN) begin
        powered_down <= 1'b1;
        unique case (lead)
          2'h1: termination <= DDAC_TERM_2K5;
          2'h2: termination <= DDAC_TERM_100K;
          2'h0, 2'h3: termination <= DDAC_TERM_HIZ;
        endcase
      end else begin
        powered_down <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Wake timer: outputs live after the wake time following exit
  logic [3:0] wake_cnt;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wake_cnt <= '0;
      outputs_live <= 1'b1; // Live at zero code after power-up
    end else if (word_end && op == DDAC_OP_PWRDN) begin
      wake_cnt <= '0;
      outputs_live <= 1'b0;
    end else if (word_end && powered_down) begin
      wake_cnt <= 4'(`DDAC_WAKE_CYC);
      outputs_live <= 1'b0;
    end else if (wake_cnt != 4'h0) begin
      wake_cnt <= wake_cnt - 4'h1;
      outputs_live <= (wake_cnt == 4'h1);
    end
  end

  // Pulse marking each executed word
  always_ff @(posedge clk) begin
    if (!resetn) begin
      word_done <= 1'b0;
    end else begin
      word_done <= word_end;
    end
  end
endmodule

// ==== design/ddac_host.sv ====
// Host end: register port takes a word and sends it on the serial link
// Assumes device samples pins through two-stage synchronisers on clk
`timescale 1ns/1ps
module ddac_host (
  input wire logic clk,
  input wire logic resetn,
  ddac_link_if.host link,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata
);
  import ddac_pkg::*;

  typedef enum logic [1:0] {
    DDAC_H_IDLE = 2'h0,
    DDAC_H_LOW = 2'h1,
    DDAC_H_HIGH = 2'h3,
    DDAC_H_GAP = 2'h2
  } ddac_hstate_e;

  ddac_hstate_e state;
  ddac_word_t word;
  logic [`DDAC_CNT_BITS-1:0] sent;
  logic [2:0] tick;
  logic busy;
  logic [15:0] words_sent;
  assign busy = (state != DDAC_H_IDLE);

  // ==========================================================
  // Sequencer: select low, clock high then low per bit, gap high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= DDAC_H_IDLE;
      word <= '0;
      sent <= '0;
      tick <= '0;
      link.frame_n <= 1'b1;
      link.sclk <= 1'b0;
      link.sdata <= 1'b0;
      words_sent <= '0;
    end else begin
      unique case (state)
        DDAC_H_IDLE: begin
          // Select drops with clock low, never on a falling edge
          if (wr && addr == `DDAC_ADDR_CMD) begin
            word <= wdata;
            word[`DDAC_LEAD_HI] <= wdata[`DDAC_LEAD_HI]; // Caller sets lead bit
            link.frame_n <= 1'b0;
            link.sdata <= wdata[`DDAC_WORD_BITS-1];
            sent <= '0;
            tick <= '0;
            state <= DDAC_H_LOW;
          end
        end
        DDAC_H_LOW: begin
          tick <= tick + 3'h1;
          // Next bit moves two ticks after the falling edge, never with it
          if (tick == `DDAC_DATA_TICK) begin
            link.sdata <= word[`DDAC_WORD_BITS-1];
          end
          if (tick == `DDAC_SCLK_HALF) begin
            link.sclk <= 1'b1;
            tick <= '0;
            state <= DDAC_H_HIGH;
          end
        end
        DDAC_H_HIGH: begin
          tick <= tick + 3'h1;
          if (tick == `DDAC_SCLK_HALF) begin
            link.sclk <= 1'b0; // Falling edge, slow clock
            tick <= '0;
            sent <= sent + 5'h1;
            word <= {word[`DDAC_WORD_BITS-2:0], 1'b0};
            if (sent == `DDAC_LAST_BIT - 5'h1) begin
              state <= DDAC_H_GAP;
            end else begin
              state <= DDAC_H_LOW;
            end
          end
        end
        DDAC_H_GAP: begin
          // Release select, park data low, hold high before next frame
          link.sdata <= 1'b0;
          tick <= tick + 3'h1;
          if (tick == `DDAC_SCLK_HALF) begin
            link.frame_n <= 1'b1;
          end
          if (tick == `DDAC_SCLK_HALF + `DDAC_GAP_CYC + 3'h2) begin
            words_sent <= words_sent + 16'h1;
            state <= DDAC_H_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        `DDAC_ADDR_CMD: rdata <= word;
        `DDAC_ADDR_STAT: rdata <= {15'h0, busy};
        `DDAC_ADDR_OUTS: rdata <= words_sent;
        `DDAC_ADDR_TERM: rdata <= 16'h0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule

// ==== verif/ddac_link_props.sv ====
// Checker for the serial link between host end and converter end
// Assumes instantiation beside the link interface in the bench top
`timescale 1ns/1ps
module ddac_link_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic frame_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic word_done,
  input wire logic powered_down,
  input wire logic outputs_live,
  input wire ddac_pkg::ddac_code_t channel_a_output,
  input wire ddac_pkg::ddac_code_t channel_b_output,
  input wire ddac_pkg::ddac_code_t pending_a,
  input wire ddac_pkg::ddac_code_t pending_b
);
  import ddac_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [4:0] edges;
  // Falling serial edges seen since the frame opened, stops at sixteen
  always_ff @(posedge clk) begin
    if (!resetn || $fell(frame_n)) begin
      edges <= 5'h0;
    end else if (!frame_n && $fell(sclk) && edges != 5'h10) begin
      edges <= edges + 5'h1;
    end
  end
  // ==========
  // Link and execution properties
  sequence s_last_edge;
    !frame_n && $fell(sclk) && edges == 5'hf;
  endsequence
  sequence s_wake;
    !outputs_live [*6] ##[1:3] outputs_live;
  endsequence
  open_clean_a: assert property ($fell(frame_n) |-> $stable(sclk))
    else $error("frame opened on a clock edge");
  idle_low_a: assert property (frame_n && $past(frame_n) |-> !sclk && !sdata)
    else $error("link not parked low between frames");
  clk_high_a: assert property ($rose(sclk) |=> sclk)
    else $error("serial clock high too short");
  data_hold_a: assert property ($fell(sclk) |-> $stable(sdata))
    else $error("data moved at sampling edge");
  gap_min_a: assert property ($rose(frame_n) |=> frame_n)
    else $error("frame select high too short");
  exec_last_a: assert property (s_last_edge |-> ##[2:6] word_done)
    else $error("no execution after sixteenth edge");
  exec_once_a: assert property (word_done |-> edges == 5'h10)
    else $error("execution without sixteen edges");
  wake_time_a: assert property ($fell(powered_down) |-> s_wake)
    else $error("wake time wrong");
  pd_dark_a: assert property (powered_down |-> !outputs_live)
    else $error("outputs live while powered down");
  pd_keep_a: assert property ($rose(powered_down) |-> $stable(pending_a) && $stable(pending_b))
    else $error("power-down altered a register");
  out_hold_a: assert property (!word_done |-> $stable(channel_a_output) && $stable(channel_b_output))
    else $error("outputs moved without a word");
endmodule

// ==== verif/tb_dual_dac_serial_write_control.sv ====
// Bench: host end drives converter end, second converter driven by bench
// Assumes design files and ddac_link_props compiled before it
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("FAIL %s exp %h got %h", n, e, g); \
    end \
  end
module tb_dual_dac_serial_write_control;
  import ddac_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0;
  logic [15:0] rdata, r;
  ddac_code_t channel_a_output, channel_b_output, pending_a, pending_b, pa2;
  logic powered_down, outputs_live, word_done, done2;
  ddac_term_e termination;
  int num_checks, bad_count, dones, dones2;
  ddac_link_if lk();
  ddac_link_if lk2();
  ddac_host u_ddac_host(.clk, .resetn, .link(lk.host), .addr, .wdata, .wr, .rd, .rdata);
  ddac_device u_ddac_device(.clk, .resetn, .link(lk.device), .channel_a_output,
    .channel_b_output, .pending_a, .pending_b, .powered_down, .termination,
    .outputs_live, .word_done);
  ddac_device u_ddac_device_2(.clk, .resetn, .link(lk2.device), .channel_a_output(),
    .channel_b_output(), .pending_a(pa2), .pending_b(), .powered_down(),
    .termination(), .outputs_live(), .word_done(done2));
  ddac_link_props u_props(.clk, .resetn, .frame_n(lk.frame_n), .sclk(lk.sclk),
    .sdata(lk.sdata), .word_done, .powered_down, .outputs_live, .channel_a_output,
    .channel_b_output, .pending_a, .pending_b);
  // Clock and executed word counters
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    dones += word_done;
    dones2 += done2;
  end
  // ==========
  // Bus and link tasks
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wreg(input logic [1:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [1:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  // Write a command, then poll busy until idle and the word executed
  task automatic send(input logic [15:0] w);
    int n0, k;
    n0 = dones;
    wreg(2'h0, w);
    for (k = 0; k < 200; k++) begin
      rreg(2'h1, r);
      if (!r[0] && dones != n0) break;
    end
    if (k == 200) begin
      bad_count++;
      complete_run();
    end
  endtask
  // Frame on the second link, n bits taken msb first from v
  task automatic frame2(input logic [19:0] v, input int n);
    lk2.frame_n <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 19; i > 19 - n; i--) begin
      lk2.sdata <= v[i];
      lk2.sclk <= 1'b1;
      repeat (3) @(posedge clk);
      lk2.sclk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    lk2.frame_n <= 1'b1;
    lk2.sdata <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // ==========
  // Scenarios
  task automatic t_loads;
    `CHK("out a", 10'h0, channel_a_output)
    `CHK("live", 1'b1, outputs_live)
    send({4'h0, 10'h2aa, 2'h3});
    `CHK("pend a", 10'h2aa, pending_a)
    `CHK("out a", 10'h0, channel_a_output)
    send({4'h5, 10'h155, 2'h0});
    `CHK("pend b", 10'h155, pending_b)
    `CHK("out a", 10'h2aa, channel_a_output)
    `CHK("out b", 10'h155, channel_b_output)
    send({4'h2, 10'h3ff, 2'h0});
    `CHK("out a", 10'h3ff, channel_a_output)
    `CHK("out b", 10'h3ff, channel_b_output)
  endtask
  task automatic t_pdown;
    logic [1:0] l;
    for (int i = 0; i < 4; i++) begin
      l = i[1:0];
      send({l, 2'h3, 12'h0});
      `CHK("pd", 1'b1, powered_down)
      `CHK("term", (l == 2'h3) ? DDAC_TERM_HIZ : ddac_term_e'(l), termination)
      `CHK("pend a", 10'h3ff, pending_a)
    end
    send({4'h1, 10'h001, 2'h0});
    `CHK("pd", 1'b0, powered_down)
    `CHK("dark", 1'b0, outputs_live)
    repeat (9) @(posedge clk);
    `CHK("live", 1'b1, outputs_live)
    `CHK("out a", 10'h001, channel_a_output)
    `CHK("out b", 10'h3ff, channel_b_output)
  endtask
  task automatic t_regs;
    rreg(2'h2, r);
    `CHK("count", 16'h8, r)
    rreg(2'h3, r);
    `CHK("zero", 16'h0, r)
    wreg(2'h1, 16'hffff);
    rreg(2'h1, r);
    `CHK("busy", 1'b0, r[0])
  endtask
  task automatic t_link2;
    frame2({4'h0, 10'h0f0, 2'h0, 4'hf}, 20);
    `CHK("extra", 10'h0f0, pa2)
    `CHK("done", 1, dones2)
    frame2({4'h1, 10'h00f, 6'h0}, 10);
    `CHK("abort", 10'h0f0, pa2)
    `CHK("done", 1, dones2)
    frame2({4'h0, 10'h30c, 2'h0, 4'h0}, 16);
    `CHK("after abort", 10'h30c, pa2)
    `CHK("done", 2, dones2)
  endtask
  // Reset, then the scenarios in order
  initial begin
    lk2.frame_n = 1'b1;
    lk2.sclk = 1'b0;
    lk2.sdata = 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_loads();
    t_pdown();
    t_regs();
    t_link2();
    complete_run();
  end
endmodule
